// file: core/twc_config_bank.v
/*
 * threshold, wake-on-change and angle post-processing configuration bank.
 * assumes a bus front end that presents byte writes/reads by address,
 * and a measurement chain that presents one new sample with a strobe.
 */
`timescale 1ns/1ps
`include "twc_map.vh"
module twc_config_bank #(
	parameter DW = 8,
	parameter AW = 12
)(
	input wire clock,
	input wire rst,
	input wire clk_en,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire [1:0] angle_pair_select,
	input wire [2:0] axis_enable_set,
	input wire limit_direction,
	input wire [DW-1:0] change_hysteresis,
	input wire sample_valid,
	input wire signed [DW-1:0] field_x,
	input wire signed [DW-1:0] field_y,
	input wire signed [DW-1:0] field_z,
	input wire signed [DW-1:0] magnitude,
	input wire [AW-1:0] angle_raw,
	output reg [AW-1:0] angle_out,
	output reg threshold_event,
	output reg change_event,
	output wire [1:0] change_wake_select,
	output wire [1:0] threshold_function_select,
	output wire [3:0] angular_hysteresis,
	output wire signed [7:0] gain_trim,
	output wire signed [7:0] first_correction_shift,
	output wire signed [7:0] second_correction_shift
);
	reg [7:0] cfg3_r;
	reg [7:0] lim1_r;
	reg [7:0] lim2_r;
	reg [7:0] lim3_r;
	reg [7:0] gain_or_x_high_byte_r;
	reg [7:0] shift1_or_y_high_byte_r;
	reg [7:0] shift2_or_z_high_byte_r;
	reg signed [DW-1:0] prev_field_r;
	reg [AW-1:0] prev_angle_r;
	reg prev_ok_r;
	reg [AW-1:0] angle_nxt;
	reg thr_nxt;
	reg chg_nxt;
	reg signed [DW-1:0] sel_field;
	reg [DW:0] fdiff;
	reg [AW-1:0] adiff;
	reg angle_in_band;
	wire signed [7:0] first_limit_byte;
	wire signed [7:0] second_limit_byte;
	wire signed [7:0] third_limit_byte;
	wire signed [AW-1:0] ofs_ext;
	wire angle_ok;
	wire signed [AW:0] angle_sx;
	wire signed [AW:0] band_lo;
	wire signed [AW:0] band_hi;
	localparam NAX = 3;
	wire [NAX-1:0] axis_hit;
	wire signed [DW-1:0] axis_val [0:NAX-1];
	wire [7:0] axis_low [0:NAX-1];
	wire [7:0] axis_high [0:NAX-1];
	genvar g;

	// sign extension of an 8-bit limit to the data width
	function signed [DW-1:0] sx;
		input signed [7:0] b;
		begin
			sx = b;
		end
	endfunction

	// gain and shift bytes are trims unless field thresholds claim them
	function trim_live;
		input [1:0] sel;
		begin
			trim_live = sel != `TWC_SEL_FIELD;
		end
	endfunction

	// beyond-limit test honouring trigger direction
	function beyond;
		input signed [DW-1:0] v;
		input signed [DW-1:0] lim;
		input dir;
		begin
			beyond = dir ? (v < lim) : (v > lim);
		end
	endfunction

	assign first_limit_byte = lim1_r;
	assign second_limit_byte = lim2_r;
	assign third_limit_byte = lim3_r;
	assign change_wake_select = cfg3_r[`TWC_WAKE_HI:`TWC_WAKE_LO];
	assign threshold_function_select = cfg3_r[`TWC_SEL_HI:`TWC_SEL_LO];
	assign angular_hysteresis = 4'h1 << cfg3_r[`TWC_HYS_HI:`TWC_HYS_LO];
	// trims only carry meaning outside field-threshold mode
	assign gain_trim = trim_live(threshold_function_select) ? gain_or_x_high_byte_r : 8'h00;
	assign first_correction_shift = trim_live(threshold_function_select) ?
		shift1_or_y_high_byte_r : 8'h00;
	assign second_correction_shift = trim_live(threshold_function_select) ?
		shift2_or_z_high_byte_r : 8'h00;
	assign ofs_ext = {{(AW-8){third_limit_byte[7]}}, third_limit_byte};
	assign angle_ok = angle_pair_select != `TWC_PAIR_NONE;

	// angle band edges, one bit wider so the signed limits never wrap
	assign angle_sx = {1'b0, angle_nxt};
	assign band_lo = {{(AW-7){first_limit_byte[7]}}, first_limit_byte};
	assign band_hi = band_lo + {{(AW-7){second_limit_byte[7]}}, second_limit_byte} +
		{{(AW-3){1'b0}}, angular_hysteresis};

	// per-axis view of samples and limit bytes for the field threshold test
	assign axis_val[`TWC_AX_X] = field_x;
	assign axis_val[`TWC_AX_Y] = field_y;
	assign axis_val[`TWC_AX_Z] = field_z;
	assign axis_low[`TWC_AX_X] = first_limit_byte;
	assign axis_low[`TWC_AX_Y] = second_limit_byte;
	assign axis_low[`TWC_AX_Z] = third_limit_byte;
	assign axis_high[`TWC_AX_X] = gain_or_x_high_byte_r;
	assign axis_high[`TWC_AX_Y] = shift1_or_y_high_byte_r;
	assign axis_high[`TWC_AX_Z] = shift2_or_z_high_byte_r;

	// an enabled axis fires when beyond either of its limits
	generate
		for (g = 0; g < NAX; g = g + 1)
		begin : g_axis
			assign axis_hit[g] = axis_enable_set[g] && (beyond(axis_val[g], sx(axis_high[g]), limit_direction) ||
				beyond(axis_val[g], sx(axis_low[g]), limit_direction));
		end
	endgenerate

	always @(posedge clock)
	begin
		if (rst)
		begin
			cfg3_r <= `TWC_CFG3_RST;
			lim1_r <= `TWC_BYTE_RST;
			lim2_r <= `TWC_BYTE_RST;
			lim3_r <= `TWC_BYTE_RST;
			gain_or_x_high_byte_r <= `TWC_BYTE_RST;
			shift1_or_y_high_byte_r <= `TWC_BYTE_RST;
			shift2_or_z_high_byte_r <= `TWC_BYTE_RST;
		end
		else if (clk_en && reg_wr)
		begin
			case (reg_addr)
				`TWC_ADDR_CFG3: cfg3_r <= reg_wdata;
				`TWC_ADDR_LIM1: lim1_r <= reg_wdata;
				`TWC_ADDR_LIM2: lim2_r <= reg_wdata;
				`TWC_ADDR_LIM3: lim3_r <= reg_wdata;
				`TWC_ADDR_GAIN: gain_or_x_high_byte_r <= reg_wdata;
				`TWC_ADDR_SH1: shift1_or_y_high_byte_r <= reg_wdata;
				`TWC_ADDR_SH2: shift2_or_z_high_byte_r <= reg_wdata;
				default: cfg3_r <= cfg3_r;
			endcase
		end
	end

	always @*
	begin
		case (reg_addr)
			`TWC_ADDR_CFG3: reg_rdata = cfg3_r;
			`TWC_ADDR_LIM1: reg_rdata = lim1_r;
			`TWC_ADDR_LIM2: reg_rdata = lim2_r;
			`TWC_ADDR_LIM3: reg_rdata = lim3_r;
			`TWC_ADDR_GAIN: reg_rdata = gain_or_x_high_byte_r;
			`TWC_ADDR_SH1: reg_rdata = shift1_or_y_high_byte_r;
			`TWC_ADDR_SH2: reg_rdata = shift2_or_z_high_byte_r;
			default: reg_rdata = 8'h00;
		endcase
	end

	always @*
	begin
		// first enabled axis drives field change wake
		if (axis_enable_set[`TWC_AX_X])
			sel_field = field_x;
		else if (axis_enable_set[`TWC_AX_Y])
			sel_field = field_y;
		else
			sel_field = field_z;
		fdiff = (sel_field > prev_field_r) ? ({sel_field[DW-1], sel_field} - {prev_field_r[DW-1], prev_field_r}) :
			({prev_field_r[DW-1], prev_field_r} - {sel_field[DW-1], sel_field});
		adiff = (angle_raw > prev_angle_r) ? (angle_raw - prev_angle_r) : (prev_angle_r - angle_raw);

		// angle offset applies only in angle-threshold mode
		angle_nxt = angle_raw;
		if (cfg3_r[`TWC_OFS_EN] && threshold_function_select == `TWC_SEL_ANGLE)
		begin
			if (cfg3_r[`TWC_OFS_DIR])
				angle_nxt = angle_raw - ofs_ext;
			else
				angle_nxt = angle_raw + ofs_ext;
		end

		// angle band test, upper edge always widened by the hysteresis
		angle_in_band = (angle_sx >= band_lo) && (angle_sx <= band_hi);

		thr_nxt = 1'b0;
		case (threshold_function_select)
			`TWC_SEL_NONE: thr_nxt = 1'b0;
			`TWC_SEL_ANGLE: thr_nxt = angle_ok && (limit_direction ? !angle_in_band : angle_in_band);
			`TWC_SEL_FIELD: thr_nxt = |axis_hit;
			`TWC_SEL_MAG: thr_nxt = limit_direction ?
				(magnitude < sx(first_limit_byte)) : (magnitude > sx(second_limit_byte));
			default: thr_nxt = 1'b0;
		endcase

		chg_nxt = 1'b0;
		case (change_wake_select)
			`TWC_WAKE_OFF: chg_nxt = 1'b0;
			`TWC_WAKE_ANGLE: chg_nxt = prev_ok_r && angle_ok &&
				(adiff >= {{(AW-DW){1'b0}}, change_hysteresis});
			`TWC_WAKE_FIELD: chg_nxt = prev_ok_r && (fdiff >= {1'b0, change_hysteresis});
			default: chg_nxt = 1'b0;
		endcase
	end

	always @(posedge clock)
	begin
		if (rst)
		begin
			prev_field_r <= {DW{1'b0}};
			prev_angle_r <= {AW{1'b0}};
			prev_ok_r <= 1'b0;
			angle_out <= {AW{1'b0}};
			threshold_event <= 1'b0;
			change_event <= 1'b0;
		end
		else if (clk_en)
		begin
			threshold_event <= sample_valid && thr_nxt;
			change_event <= sample_valid && chg_nxt;
			if (sample_valid)
			begin
				prev_field_r <= sel_field;
				prev_angle_r <= angle_raw;
				prev_ok_r <= 1'b1;
				angle_out <= angle_nxt;
			end
		end
	end
endmodule

// file: core/twc_map.vh
/*
 * constants for the threshold / wake-on-change configuration bank:
 * register addresses, field positions, codes and reset values.
 * assumes inclusion by bare name from the single design module.
 */
`ifndef TWC_MAP_VH
`define TWC_MAP_VH
`define TWC_ADDR_LIM1 8'h04
`define TWC_ADDR_LIM2 8'h05
`define TWC_ADDR_LIM3 8'h06
`define TWC_ADDR_CFG3 8'h07
`define TWC_ADDR_GAIN 8'h09
`define TWC_ADDR_SH1 8'h0a
`define TWC_ADDR_SH2 8'h0b
`define TWC_CFG3_RST 8'h00
`define TWC_BYTE_RST 8'h00
`define TWC_WAKE_HI 7
`define TWC_WAKE_LO 6
`define TWC_SEL_HI 5
`define TWC_SEL_LO 4
`define TWC_HYS_HI 3
`define TWC_HYS_LO 2
`define TWC_OFS_EN 1
`define TWC_OFS_DIR 0
`define TWC_WAKE_OFF 2'h0
`define TWC_WAKE_ANGLE 2'h1
`define TWC_WAKE_FIELD 2'h2
`define TWC_SEL_NONE 2'h0
`define TWC_SEL_ANGLE 2'h1
`define TWC_SEL_FIELD 2'h2
`define TWC_SEL_MAG 2'h3
`define TWC_PAIR_NONE 2'h0
`define TWC_PAIR_XY 2'h1
`define TWC_PAIR_YZ 2'h2
`define TWC_PAIR_XZ 2'h3
`define TWC_AX_X 0
`define TWC_AX_Y 1
`define TWC_AX_Z 2
`endif

// file: testbench/twc_asserts.sv
/* port checker for the config bank
   assumes bind onto twc_config_bank */
`timescale 1ns/1ps
module twc_asserts #(
	parameter AW = 12
)(
	input wire clock,
	input wire rst,
	input wire clk_en,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire sample_valid,
	input wire [AW-1:0] angle_out,
	input wire threshold_event,
	input wire change_event,
	input wire [1:0] change_wake_select,
	input wire [1:0] threshold_function_select,
	input wire [3:0] angular_hysteresis,
	input wire signed [7:0] gain_trim
);
default clocking cb @(posedge clock);
endclocking
default disable iff (rst);
sequence s_cfg_wr; clk_en && reg_wr && reg_addr == 8'h07; endsequence
property p_wake_wr; s_cfg_wr |=> change_wake_select == $past(reg_wdata[7:6]); endproperty
a_wake_wr: assert property (p_wake_wr) else $error("wake select not loaded");
property p_sel_wr; s_cfg_wr |=> threshold_function_select == $past(reg_wdata[5:4]); endproperty
a_sel_wr: assert property (p_sel_wr) else $error("select not loaded");
property p_hys; reg_addr == 8'h07 |-> angular_hysteresis == 4'h1 << reg_rdata[3:2]; endproperty
a_hys: assert property (p_hys) else $error("bad hysteresis");
property p_xhigh; threshold_function_select == 2'h2 |-> gain_trim == 8'sh00; endproperty
a_xhigh: assert property (p_xhigh) else $error("trim live in field mode");
property p_trim; threshold_function_select != 2'h2 && reg_addr == 8'h09 |-> gain_trim == reg_rdata; endproperty
a_trim: assert property (p_trim) else $error("trim differs from byte");
property p_wake_off; change_event |-> $past(sample_valid) && $past(change_wake_select) inside {2'h1, 2'h2};
endproperty
a_wake_off: assert property (p_wake_off) else $error("change event while off");
property p_thr_off; threshold_event |-> $past(threshold_function_select) != 2'h0; endproperty
a_thr_off: assert property (p_thr_off) else $error("threshold event while off");
property p_hold; !(clk_en && sample_valid) |=> $stable(angle_out); endproperty
a_hold: assert property (p_hold) else $error("angle moved without sample");
endmodule
bind twc_config_bank twc_asserts #(.AW(AW)) u_chk (.clock, .rst, .clk_en, .reg_addr, .reg_wr, .reg_wdata,
	.reg_rdata, .sample_valid, .angle_out, .threshold_event, .change_event, .change_wake_select,
	.threshold_function_select, .angular_hysteresis, .gain_trim);

// file: testbench/twc_config_bank_tb.sv
/* bench for twc_config_bank
   assumes the host model and bound checker */
`timescale 1ns/1ps
module twc_config_bank_tb;
logic clock = 0, rst = 1, clk_en = 1, sample_valid = 0, limit_direction = 0;
logic signed [7:0] field_x = 0, field_y = 0, field_z = 0, magnitude = 0;
logic [11:0] angle_raw = 0;
logic [2:0] axis_enable_set = 3'h6;
logic [7:0] change_hysteresis = 8'h04;
wire [7:0] reg_addr, reg_wdata, reg_rdata;
wire reg_wr, threshold_event, change_event;
wire [1:0] angle_pair_select, change_wake_select, threshold_function_select;
wire [3:0] angular_hysteresis;
wire signed [7:0] gain_trim, first_correction_shift, second_correction_shift;
wire [11:0] angle_out;
int errors = 0, tests_run = 0, cyc = 0, i;
always #4 clock = ~clock;
twc_host h (.clock, .reg_addr, .reg_wr, .reg_wdata, .angle_pair_select);
twc_config_bank DUT (.clock, .rst, .clk_en, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .angle_pair_select,
	.axis_enable_set, .limit_direction, .change_hysteresis, .sample_valid, .field_x, .field_y, .field_z,
	.magnitude, .angle_raw, .angle_out, .threshold_event, .change_event, .change_wake_select,
	.threshold_function_select, .angular_hysteresis, .gain_trim, .first_correction_shift,
	.second_correction_shift);
task chk(input string n, input logic [11:0] s, input logic [11:0] e);
begin
	tests_run++;
	if (s !== e)
	begin
		errors++;
		$display("wrong value %s expected %h seen %h", n, e, s);
	end
end
endtask
task smp(input [7:0] y, input [7:0] m, input [11:0] a);
begin
	@(posedge clock) #1;
	field_x = ~y;
	field_y = y;
	field_z = ~m;
	magnitude = m;
	angle_raw = a;
	sample_valid = 1'h1;
	@(posedge clock) #1;
	sample_valid = 1'h0;
end
endtask
task t_regs;
begin
	for (i = 4; i < 12; i++)
	begin
		h.pt(i[7:0]);
		chk("reset", reg_rdata, 8'h00);
	end
	h.wr(8'h09, 8'hfb);
	chk("trim", gain_trim[7:0], 8'hfb);
	h.wr(8'h07, 8'h20);
	chk("trim", gain_trim[7:0], 8'h00);
end
endtask
task t_hys;
begin
	for (i = 0; i < 4; i++)
	begin
		h.wr(8'h07, {4'h0, i[1:0], 2'h0});
		chk("hys", angular_hysteresis, 4'h1 << i[1:0]);
	end
end
endtask
task t_ofs;
	logic [7:0] cf [4];
	logic [11:0] ex [4];
begin
	cf = '{8'h10, 8'h12, 8'h13, 8'h32};
	ex = '{12'h064, 12'h061, 12'h067, 12'h064};
	h.wr(8'h06, 8'hfd);
	for (i = 0; i < 4; i++)
	begin
		h.wr(8'h07, cf[i]);
		smp(8'h00, 8'h00, 12'h064);
		chk("angle", angle_out, ex[i]);
	end
end
endtask
task t_mag;
begin
	h.wr(8'h04, 8'h0a);
	h.wr(8'h05, 8'h14);
	h.wr(8'h07, 8'h30);
	smp(8'h00, 8'h1e, 12'h000);
	chk("mag", threshold_event, 1'h1);
	smp(8'h00, 8'h0f, 12'h000);
	chk("mag", threshold_event, 1'h0);
	limit_direction = 1'h1;
	smp(8'h00, 8'h05, 12'h000);
	chk("mag", threshold_event, 1'h1);
	smp(8'h00, 8'h0f, 12'h000);
	chk("mag", threshold_event, 1'h0);
end
endtask
task t_wake;
begin
	h.wr(8'h07, 8'h80);
	smp(8'h00, 8'h00, 12'h000);
	smp(8'h03, 8'h00, 12'h000);
	chk("chg", change_event, 1'h0);
	smp(8'h07, 8'h40, 12'h000);
	chk("chg", change_event, 1'h1);
	chk("thr", threshold_event, 1'h0);
	h.wr(8'h07, 8'hc0);
	smp(8'h64, 8'h00, 12'h000);
	chk("chg", change_event, 1'h0);
end
endtask
task t_field;
begin
	limit_direction = 1'h0;
	h.wr(8'h05, 8'h10);
	h.wr(8'h06, 8'hf0);
	h.wr(8'h0a, 8'h20);
	h.wr(8'h0b, 8'h20);
	h.wr(8'h07, 8'h20);
	smp(8'h05, 8'h30, 12'h000);
	chk("fld", threshold_event, 1'h0);
	smp(8'h18, 8'h30, 12'h000);
	chk("fld", threshold_event, 1'h1);
	smp(8'h05, 8'hfa, 12'h000);
	chk("fld", threshold_event, 1'h1);
end
endtask
task t_angle;
begin
	h.wr(8'h04, 8'h10);
	h.wr(8'h05, 8'h20);
	h.wr(8'h07, 8'h10);
	chk("sh1", first_correction_shift, 8'h20);
	chk("sh2", second_correction_shift, 8'h20);
	smp(8'h00, 8'h00, 12'h020);
	chk("ang", threshold_event, 1'h1);
	smp(8'h00, 8'h00, 12'h040);
	chk("ang", threshold_event, 1'h0);
	h.wr(8'h07, 8'h40);
	smp(8'h00, 8'h00, 12'h042);
	chk("achg", change_event, 1'h0);
	smp(8'h00, 8'h00, 12'h046);
	chk("achg", change_event, 1'h1);
	h.pair(2'h0);
	smp(8'h00, 8'h00, 12'h050);
	chk("achg", change_event, 1'h0);
	h.pair(2'h1);
end
endtask
task conclude;
begin
	$display("checks %0d errors %0d", tests_run, errors);
	if (errors == 0 && tests_run > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
end
endtask
always @(posedge clock)
begin
	cyc++;
	if (cyc == 5000)
	begin
		errors++;
		conclude;
	end
end
initial
begin
	repeat (16) @(posedge clock);
	#1 rst = 1'h0;
	t_regs;
	t_hys;
	t_ofs;
	t_mag;
	t_wake;
	t_field;
	t_angle;
	conclude;
end
endmodule

// file: testbench/twc_host.sv
/* host controller model writing config bytes
   assumes the bank's byte write port */
`timescale 1ns/1ps
module twc_host (
	input wire clock,
	output reg [7:0] reg_addr = 8'h00,
	output reg reg_wr = 1'h0,
	output reg [7:0] reg_wdata = 8'h00,
	output reg [1:0] angle_pair_select = 2'h1
);
task pt(input [7:0] a);
begin
	@(posedge clock) #1;
	reg_addr = a;
	#1;
end
endtask
task pair(input [1:0] p);
begin
	@(posedge clock) #1;
	angle_pair_select = p;
end
endtask
task wr(input [7:0] a, input [7:0] d);
begin
	@(posedge clock) #1;
	reg_addr = a;
	reg_wdata = d;
	reg_wr = 1'h1;
	@(posedge clock) #1;
	reg_wr = 1'h0;
	reg_wdata = ~d;
end
endtask
endmodule
